/* File: logic/clkgen_ctrl.sv */
// System controller end: drives the clock generator control pins and
// configuration writes from software over APB.
// Assumes an APB master on the same clock; zero-wait, one word per register.
`timescale 1ns/1ps
`include "clkgen_map.svh"
module clkgen_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Link to clock generator
	clkgen_link_if.ctrl link
);
	logic sw_power, pd_initial, cpu_mn_ok, cpu_n_ok, pcie_n_ok;
	logic [3:0] pg_cnt;
	logic [31:0] next_rdata;
	logic next_err, refuse, done_wr;
	logic [2:0] cmd_sel;

	// ------------------------------------------------------------
	// Decode at the setup cycle
	// ------------------------------------------------------------
	assign cmd_sel = i_pwdata[`C_SEL_MSB:`C_SEL_LSB];
	// Enabling programmed frequency on values not loaded since controller reset is refused; a device power-down wipe does not clear the flags
	assign refuse = cmd_sel == `SEL_ENABLES &&
		((i_pwdata[`EN_CPU] && !(cpu_mn_ok && cpu_n_ok)) || (i_pwdata[`EN_PCIE] && !pcie_n_ok));
	assign done_wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

	always_comb begin
		next_err = 1'b0;
		next_rdata = 32'h0000_0000;
		case (i_paddr)
			`A_PINS: next_rdata = {22'h00_0000, pd_initial, link.freq_select_straps, 1'b0,
				link.pci_clk_stop_n, link.cpu_clk_stop_n, sw_power};
			`A_CMD: next_err = i_pwrite && refuse;
			`A_STATUS: next_rdata = {21'h00_0000, pcie_n_ok, cpu_n_ok, cpu_mn_ok, link.power_good_pd,
				link.diff_oe, link.pcie_ref_clk_comp, link.pcie_ref_clk_true, link.pci_free_running_clk,
				link.pci_clk, link.cpu_clk_comp, link.cpu_clk_true};
			`A_FREQ: next_rdata = {link.pcie_freq, link.cpu_freq};
			default: next_err = 1'b1;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && next_err;
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? next_rdata : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Pin register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sw_power <= 1'b0;
			pd_initial <= 1'b0;
			link.cpu_clk_stop_n <= 1'b1;
			link.pci_clk_stop_n <= 1'b1;
			link.freq_select_straps <= 5'h00;
		end else if (done_wr && i_paddr == `A_PINS) begin
			sw_power <= i_pwdata[`P_PWR];
			pd_initial <= i_pwdata[`P_PDINIT];
			link.cpu_clk_stop_n <= i_pwdata[`P_CPUSTP];
			link.pci_clk_stop_n <= i_pwdata[`P_PCISTP];
			link.freq_select_straps <= i_pwdata[`P_STRAP_MSB:`P_STRAP_LSB];
		end
	end

	// Power-good is held just long enough to be sampled, then pulled low
	// again when power-down is wanted as the first state
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pg_cnt <= 4'h0;
			link.power_good_pd <= 1'b0;
		end else begin
			if (!sw_power || !pd_initial)
				pg_cnt <= 4'h0;
			else if (pg_cnt != `PG_HOLD_CYC)
				pg_cnt <= pg_cnt + 4'h1;
			link.power_good_pd <= sw_power && !(pd_initial && pg_cnt == `PG_HOLD_CYC);
		end
	end

	// ------------------------------------------------------------
	// Configuration commands
	// ------------------------------------------------------------
	// All commands share the A_CMD register, so one enables write can retune both PLLs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			link.cfg_valid <= 1'b0;
			link.cfg_sel <= 3'h0;
			link.cfg_data <= 16'h0000;
			cpu_mn_ok <= 1'b0;
			cpu_n_ok <= 1'b0;
			pcie_n_ok <= 1'b0;
		end else begin
			link.cfg_valid <= done_wr && i_paddr == `A_CMD;
			if (done_wr && i_paddr == `A_CMD) begin
				link.cfg_sel <= cmd_sel;
				link.cfg_data <= i_pwdata[`M_MSB:0];
				if (cmd_sel == `SEL_CPU_MN) begin
					cpu_mn_ok <= i_pwdata[`M_MSB:`M_LSB] != `DIV_RST;
					cpu_n_ok <= i_pwdata[`N_MSB:0] != `MULT_RST;
				end
				if (cmd_sel == `SEL_CPU_N)
					cpu_n_ok <= i_pwdata[`N_MSB:0] != `MULT_RST;
				if (cmd_sel == `SEL_PCIE_N)
					pcie_n_ok <= i_pwdata[`N_MSB:0] != `MULT_RST;
			end
		end
	end
endmodule

/* File: logic/clkgen_device.sv */
// Clock generator control end: frequency programming, shared smooth
// switch, power-down handling and synchronous CPU/PCI stop.
// Assumes control pins come from another party through clkgen_link_if.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "clkgen_map.svh"
module clkgen_device #(
	parameter int LOCK_CYCLES = `T_LOCK_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Link to controller
	clkgen_link_if.device link,
	// Status
	output logic [2:0] o_power_state,
	output logic o_ss_owner_pcie
);
	clkgen_pkg::pwr_state_t state;
	clkgen_pkg::ss_owner_t auto_owner;
	clkgen_pkg::ss_owner_t own;
	logic restore, mgmt, cpu_en, pcie_en, ss_manual, ss_pcie;
	logic [`N_MSB:0] cpu_n, pcie_n;
	logic [`M_MSB-`M_LSB:0] cpu_m;
	logic [`ST_MSB:0] stops;
	logic [4:0] straps;
	logic pwr_s, cpu_clk_stop_n_s, pci_clk_stop_n_s;
	logic cpu_phase, cpu_held, pci_held, se_off, full_reset;
	logic [1:0] pd_cnt, cstp_cnt, pci_cnt;
	logic [18:0] lock_cnt;
	logic [7:0] slew_cnt, gear;
	logic [15:0] cpu_target, pcie_target;
	logic step_tick, diff_off, se_run, pcie_held;

	// ------------------------------------------------------------
	// Frequency arithmetic
	// ------------------------------------------------------------
	function automatic logic [15:0] freq_calc(input logic [7:0] g, input logic [8:0] n, input logic [6:0] m);
		logic [16:0] p;
		logic [16:0] q;
		p = {9'h000, g} * {8'h00, n};
		q = (m == `DIV_RST) ? 17'h0_0000 : p / {10'h000, m};
		return q[15:0];
	endfunction

	function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] tgt);
		if (cur < tgt)
			return cur + 16'h0001;
		else if (cur > tgt)
			return cur - 16'h0001;
		else
			return cur;
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	sync2 #(.RST_VAL(1'b0)) u_sync_pwr (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(link.power_good_pd), .o_q(pwr_s));
	sync2 #(.RST_VAL(1'b1)) u_sync_cpu (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(link.cpu_clk_stop_n), .o_q(cpu_clk_stop_n_s));
	sync2 #(.RST_VAL(1'b1)) u_sync_pci (.i_clk(i_clk), .i_resetn(i_resetn), .i_d(link.pci_clk_stop_n), .o_q(pci_clk_stop_n_s));

	// ------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------
	// No restore and no management mode: power-down wipes everything
	assign full_reset = (state == clkgen_pkg::STOPPING) && se_off && !restore && !mgmt;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			restore <= 1'b0;
			mgmt <= 1'b0;
			cpu_n <= `MULT_RST;
			cpu_m <= `DIV_RST;
			pcie_n <= `MULT_RST;
			cpu_en <= 1'b0;
			pcie_en <= 1'b0;
			ss_manual <= 1'b0;
			ss_pcie <= 1'b0;
			stops <= `STOPS_RST;
		end else if (full_reset) begin
			restore <= 1'b0;
			mgmt <= 1'b0;
			cpu_n <= `MULT_RST;
			cpu_m <= `DIV_RST;
			pcie_n <= `MULT_RST;
			cpu_en <= 1'b0;
			pcie_en <= 1'b0;
			ss_manual <= 1'b0;
			ss_pcie <= 1'b0;
			stops <= `STOPS_RST;
		end else if (link.cfg_valid) begin
			case (link.cfg_sel)
				`SEL_BYTE0: begin
					restore <= link.cfg_data[`B0_RESTORE];
					mgmt <= link.cfg_data[`B0_MGMT];
				end
				`SEL_CPU_MN: begin
					cpu_n <= link.cfg_data[`N_MSB:0];
					cpu_m <= link.cfg_data[`M_MSB:`M_LSB];
				end
				`SEL_CPU_N: cpu_n <= link.cfg_data[`N_MSB:0];
				`SEL_PCIE_N: pcie_n <= link.cfg_data[`N_MSB:0];
				`SEL_ENABLES: begin
					cpu_en <= link.cfg_data[`EN_CPU];
					pcie_en <= link.cfg_data[`EN_PCIE];
					ss_manual <= link.cfg_data[`EN_SS_MANUAL];
					ss_pcie <= link.cfg_data[`EN_SS_PCIE];
				end
				`SEL_STOPS: stops <= link.cfg_data[`ST_MSB:0];
				default: ;
			endcase
		end
	end

	// Straps are only followed while latches are open
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			straps <= 5'h00;
		else if (state == clkgen_pkg::LATCHES_OPEN)
			straps <= link.freq_select_straps;
	end

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= clkgen_pkg::LATCHES_OPEN;
			lock_cnt <= 19'h0_0000;
		end else begin
			case (state)
				clkgen_pkg::LATCHES_OPEN: begin
					lock_cnt <= 19'h0_0000;
					if (pwr_s)
						state <= clkgen_pkg::WAKING;
				end
				clkgen_pkg::WAKING: begin
					lock_cnt <= lock_cnt + 19'h0_0001;
					if (!pwr_s)
						state <= clkgen_pkg::STOPPING;
					else if (lock_cnt == 19'(LOCK_CYCLES - 1))
						state <= clkgen_pkg::RUNNING;
				end
				clkgen_pkg::RUNNING: begin
					if (pd_cnt == `STOP_SAMPLES)
						state <= clkgen_pkg::STOPPING;
				end
				clkgen_pkg::STOPPING: begin
					if (se_off)
						state <= full_reset ? clkgen_pkg::LATCHES_OPEN : clkgen_pkg::POWERED_DOWN;
				end
				clkgen_pkg::POWERED_DOWN: begin
					lock_cnt <= 19'h0_0000;
					if (pwr_s)
						state <= clkgen_pkg::WAKING;
				end
				default: state <= clkgen_pkg::LATCHES_OPEN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Internal clock phases and edge sampling
	// ------------------------------------------------------------
	// cpu_phase high means the next edge is a true rising edge
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cpu_phase <= 1'b0;
			pci_cnt <= 2'h0;
		end else begin
			cpu_phase <= ~cpu_phase;
			pci_cnt <= pci_cnt + 2'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			pd_cnt <= 2'h0;
		else if (state != clkgen_pkg::RUNNING || pwr_s)
			pd_cnt <= 2'h0;
		else if (cpu_phase && pd_cnt != `STOP_SAMPLES)
			pd_cnt <= pd_cnt + 2'h1;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			cstp_cnt <= 2'h0;
		else if (cpu_clk_stop_n_s)
			cstp_cnt <= 2'h0;
		else if (cpu_phase && cstp_cnt != `STOP_SAMPLES)
			cstp_cnt <= cstp_cnt + 2'h1;
	end

	// ------------------------------------------------------------
	// Stop gating
	// ------------------------------------------------------------
	// Freeze only where true is high and release only where it falls,
	// so no pulse is ever shortened
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			cpu_held <= 1'b0;
		else if (cpu_held)
			cpu_held <= !(cpu_phase && cstp_cnt != `STOP_SAMPLES);
		else
			cpu_held <= !cpu_phase && cstp_cnt == `STOP_SAMPLES && stops[`ST_CPU];
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			pci_held <= 1'b0;
		else if (pci_cnt == `PCI_LAST)
			pci_held <= !pci_clk_stop_n_s;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			se_off <= 1'b0;
		else if (state == clkgen_pkg::STOPPING)
			se_off <= se_off || pci_cnt == `PCI_LAST;
		else
			se_off <= 1'b0;
	end

	// ------------------------------------------------------------
	// Output drivers
	// ------------------------------------------------------------
	assign diff_off = state != clkgen_pkg::RUNNING;
	assign se_run = state == clkgen_pkg::RUNNING || (state == clkgen_pkg::STOPPING && !se_off);
	assign pcie_held = pci_held && stops[`ST_PCIE];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			link.cpu_clk_true <= 1'b0;
			link.cpu_clk_comp <= 1'b0;
			link.pcie_ref_clk_true <= 1'b0;
			link.pcie_ref_clk_comp <= 1'b0;
			link.pci_clk <= 1'b0;
			link.pci_free_running_clk <= 1'b0;
			link.diff_oe <= 1'b0;
			o_power_state <= 3'h0;
		end else begin
			link.cpu_clk_true <= !diff_off && (cpu_held || cpu_phase);
			link.cpu_clk_comp <= !diff_off && !cpu_held && !cpu_phase;
			link.pcie_ref_clk_true <= !diff_off && (pcie_held || cpu_phase);
			link.pcie_ref_clk_comp <= !diff_off && !pcie_held && !cpu_phase;
			link.pci_clk <= se_run && !pci_held && pci_cnt[1];
			link.pci_free_running_clk <= se_run && !(pci_held && stops[`ST_PCI_FREE_RUNNING_CLK]) && pci_cnt[1];
			// Three-stated while down, driven again as soon as wake starts
			link.diff_oe <= state == clkgen_pkg::WAKING || state == clkgen_pkg::RUNNING ||
				state == clkgen_pkg::STOPPING;
			o_power_state <= state;
		end
	end

	// ------------------------------------------------------------
	// Frequency targets and shared smooth switch
	// ------------------------------------------------------------
	assign gear = `GEAR_BASE + {3'b000, straps};
	assign cpu_target = cpu_en ? freq_calc(gear, cpu_n, cpu_m) : freq_calc(gear, `STD_N, `STD_M);
	assign pcie_target = freq_calc(gear, pcie_en ? pcie_n : `STD_N, `PCIE_M);
	assign own = ss_manual ? (ss_pcie ? clkgen_pkg::SS_PCIE : clkgen_pkg::SS_CPU) : auto_owner;
	assign step_tick = slew_cnt == 8'(`SLEW_CYC - 1);

	// Auto mode only hands the circuit over once the current ramp ends
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			auto_owner <= clkgen_pkg::SS_CPU;
		else if ((own == clkgen_pkg::SS_CPU) ? link.cpu_freq == cpu_target : link.pcie_freq == pcie_target) begin
			if (link.pcie_freq != pcie_target)
				auto_owner <= clkgen_pkg::SS_PCIE;
			else if (link.cpu_freq != cpu_target)
				auto_owner <= clkgen_pkg::SS_CPU;
		end
	end

	// One unit per slew interval bounds rate and avoids any overshoot
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			slew_cnt <= 8'h00;
			link.cpu_freq <= 16'h0000;
			link.pcie_freq <= 16'h0000;
			o_ss_owner_pcie <= 1'b0;
		end else begin
			slew_cnt <= step_tick ? 8'h00 : slew_cnt + 8'h01;
			o_ss_owner_pcie <= own == clkgen_pkg::SS_PCIE;
			if (state != clkgen_pkg::RUNNING || own != clkgen_pkg::SS_CPU)
				link.cpu_freq <= cpu_target;
			else if (step_tick)
				link.cpu_freq <= step_to(link.cpu_freq, cpu_target);
			if (state != clkgen_pkg::RUNNING || own != clkgen_pkg::SS_PCIE)
				link.pcie_freq <= pcie_target;
			else if (step_tick)
				link.pcie_freq <= step_to(link.pcie_freq, pcie_target);
		end
	end
endmodule

/* File: logic/clkgen_link_if.sv */
// Link between the system controller and the clock generator.
// Assumes both ends share i_clk; the bench instantiates it.
`timescale 1ns/1ps
`include "clkgen_map.svh"
interface clkgen_link_if;
	logic power_good_pd;
	logic cpu_clk_stop_n;
	logic pci_clk_stop_n;
	logic [4:0] freq_select_straps;
	logic cfg_valid;
	logic [2:0] cfg_sel;
	logic [`M_MSB:0] cfg_data;
	logic cpu_clk_true;
	logic cpu_clk_comp;
	logic pci_clk;
	logic pci_free_running_clk;
	logic pcie_ref_clk_true;
	logic pcie_ref_clk_comp;
	logic diff_oe;
	logic [15:0] cpu_freq;
	logic [15:0] pcie_freq;
	modport device(input power_good_pd, cpu_clk_stop_n, pci_clk_stop_n, freq_select_straps, cfg_valid,
		cfg_sel, cfg_data, output cpu_clk_true, cpu_clk_comp, pci_clk, pci_free_running_clk,
		pcie_ref_clk_true, pcie_ref_clk_comp, diff_oe, cpu_freq, pcie_freq);
	modport ctrl(output power_good_pd, cpu_clk_stop_n, pci_clk_stop_n, freq_select_straps, cfg_valid,
		cfg_sel, cfg_data, input cpu_clk_true, cpu_clk_comp, pci_clk, pci_free_running_clk,
		pcie_ref_clk_true, pcie_ref_clk_comp, diff_oe, cpu_freq, pcie_freq);
endinterface

/* File: logic/clkgen_map.svh */
// Constants shared by the clock generator control ends.
// Assumes a 250 MHz system clock on both ends.
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

// ------------------------------------------------------------
// Configuration write selectors and fields
// ------------------------------------------------------------
`define SEL_BYTE0 3'h0
`define SEL_CPU_MN 3'h1
`define SEL_CPU_N 3'h2
`define SEL_PCIE_N 3'h3
`define SEL_ENABLES 3'h4
`define SEL_STOPS 3'h5
`define B0_RESTORE 0
`define B0_MGMT 3
`define EN_CPU 0
`define EN_PCIE 1
`define EN_SS_MANUAL 2
`define EN_SS_PCIE 3
`define ST_CPU 0
`define ST_PCI_FREE_RUNNING_CLK 1
`define ST_PCIE 2
`define ST_MSB 2
`define N_MSB 8
`define M_LSB 9
`define M_MSB 15
`define STOPS_RST 3'h5
`define MULT_RST 9'h000
`define DIV_RST 7'h00

// ------------------------------------------------------------
// Frequency arithmetic
// ------------------------------------------------------------
`define GEAR_BASE 8'h10
`define STD_N 9'h064
`define STD_M 7'h04
`define PCIE_M 7'h04

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define T_SLEW_NS 667
`define SLEW_CYC ((`T_SLEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_LOCK_NS 1800000
`define T_PD_INIT_NS 10000
`define PD_INIT_MAX_CYC (`T_PD_INIT_NS / `CLK_PERIOD_NS)
`define PG_HOLD_CYC 4'h8
`define STOP_SAMPLES 2'h2
`define PCI_LAST 2'h3

// ------------------------------------------------------------
// Controller APB map
// ------------------------------------------------------------
`define A_PINS 12'h000
`define A_CMD 12'h004
`define A_STATUS 12'h008
`define A_FREQ 12'h00C
`define P_PWR 0
`define P_CPUSTP 1
`define P_PCISTP 2
`define P_STRAP_LSB 4
`define P_STRAP_MSB 8
`define P_PDINIT 9
`define C_SEL_LSB 16
`define C_SEL_MSB 18

`endif

/* File: logic/clkgen_pkg.sv */
// Types shared by the clock generator control ends.
// Assumes clkgen_map.svh supplies all numeric constants.
package clkgen_pkg;
	typedef enum logic [2:0] {
		LATCHES_OPEN = 3'b000,
		WAKING = 3'b001,
		RUNNING = 3'b010,
		STOPPING = 3'b011,
		POWERED_DOWN = 3'b100
	} pwr_state_t;
	typedef enum logic {
		SS_CPU = 1'b0,
		SS_PCIE = 1'b1
	} ss_owner_t;
endpackage

/* File: logic/sync2.sv */
// Two-stage level synchroniser.
// Assumes the input may change at any time relative to i_clk.
`timescale 1ns/1ps
module sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Data
	input wire logic i_d,
	output logic o_q
);
	logic meta;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule

/* File: sim/clkgen_sva.sv */
// Assertions on the link between controller and clock generator.
// Assumes one clock domain; the bench wires the link signals by name.
`timescale 1ns/1ps
module clkgen_sva (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Link
	input wire logic power_good_pd,
	input wire logic cpu_clk_stop_n,
	input wire logic pci_clk_stop_n,
	input wire logic cpu_clk_true,
	input wire logic cpu_clk_comp,
	input wire logic pci_clk,
	input wire logic pci_free_running_clk,
	input wire logic pcie_ref_clk_true,
	input wire logic pcie_ref_clk_comp,
	input wire logic diff_oe
);
	// ----------------------------------------
	// Hold counters, saturating at 31
	// ----------------------------------------
	logic [4:0] cpu_cnt;
	logic [4:0] pci_cnt;
	logic [4:0] pd_cnt;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) cpu_cnt <= 5'h00;
		else if (cpu_clk_stop_n || !power_good_pd) cpu_cnt <= 5'h00;
		else if (cpu_cnt != 5'h1f) cpu_cnt <= cpu_cnt + 5'h01;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) pci_cnt <= 5'h00;
		else if (pci_clk_stop_n || !power_good_pd) pci_cnt <= 5'h00;
		else if (pci_cnt != 5'h1f) pci_cnt <= pci_cnt + 5'h01;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) pd_cnt <= 5'h00;
		else if (power_good_pd) pd_cnt <= 5'h00;
		else if (pd_cnt != 5'h1f) pd_cnt <= pd_cnt + 5'h01;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_cpu_release;
		$rose(cpu_clk_stop_n) && cpu_cnt == 5'h1f;
	endsequence
	sequence s_pci_release;
		$rose(pci_clk_stop_n) && pci_cnt == 5'h1f;
	endsequence
	property p_cpu_pair; !(cpu_clk_true && cpu_clk_comp); endproperty
	property p_pcie_pair; !(pcie_ref_clk_true && pcie_ref_clk_comp); endproperty
	property p_pd_quiet; pd_cnt == 5'h1f |-> !(diff_oe | cpu_clk_true | pci_clk | pci_free_running_clk); endproperty
	property p_cpu_stop; cpu_cnt == 5'h1f |-> cpu_clk_true && !cpu_clk_comp; endproperty
	property p_cpu_resume; s_cpu_release |-> ##[1:12] $rose(cpu_clk_comp); endproperty
	property p_pci_stop; pci_cnt == 5'h1f |-> !pci_clk; endproperty
	property p_pci_free_running_clk_run; pci_cnt == 5'h1f |-> ##[0:2] $changed(pci_free_running_clk); endproperty
	property p_pcie_held; pci_cnt == 5'h1f |-> pcie_ref_clk_true && !pcie_ref_clk_comp; endproperty
	property p_pci_resume; s_pci_release |-> ##[1:16] $rose(pci_clk); endproperty
	property p_wake; $rose(power_good_pd) && !diff_oe |-> ##[1:6] diff_oe; endproperty
	a_cpu_pair: assert property (p_cpu_pair) else $error("cpu pair both high");
	a_pcie_pair: assert property (p_pcie_pair) else $error("pcie pair both high");
	a_pd_quiet: assert property (p_pd_quiet) else $error("clocks alive in power-down");
	a_cpu_stop: assert property (p_cpu_stop) else $error("cpu not held stopped");
	a_cpu_resume: assert property (p_cpu_resume) else $error("cpu late to resume");
	a_pci_stop: assert property (p_pci_stop) else $error("pci not held low");
	a_pci_free_running_clk_run: assert property (p_pci_free_running_clk_run) else $error("free pci stopped");
	a_pcie_held: assert property (p_pcie_held) else $error("pcie not held");
	a_pci_resume: assert property (p_pci_resume) else $error("pci late to resume");
	a_wake: assert property (p_wake) else $error("no wake after power good");
endmodule

/* File: sim/tb_top.sv */
// Bench joining controller and clock generator over the link.
// Assumes a 250 MHz clock; software acts over the controller APB port.
`timescale 1ns/1ps
`include "clkgen_map.svh"
module tb_top;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] pstate;
	logic owner;
	logic [31:0] rdata;
	logic rerr;
	int n_errors = 0;
	int compares = 0;
	clkgen_link_if link();
	always #2 i_clk = ~i_clk;
	clkgen_ctrl u_clkgen_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .link(link));
	// Short lock time keeps every wake inside the run budget
	clkgen_device #(.LOCK_CYCLES(16)) u_clkgen_device (.i_clk(i_clk), .i_resetn(i_resetn), .link(link),
		.o_power_state(pstate), .o_ss_owner_pcie(owner));
	clkgen_sva u_clkgen_sva (.i_clk(i_clk), .i_resetn(i_resetn), .power_good_pd(link.power_good_pd),
		.cpu_clk_stop_n(link.cpu_clk_stop_n), .pci_clk_stop_n(link.pci_clk_stop_n),
		.cpu_clk_true(link.cpu_clk_true), .cpu_clk_comp(link.cpu_clk_comp), .pci_clk(link.pci_clk),
		.pci_free_running_clk(link.pci_free_running_clk), .pcie_ref_clk_true(link.pcie_ref_clk_true),
		.pcie_ref_clk_comp(link.pcie_ref_clk_comp), .diff_oe(link.diff_oe));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] f(input int n, input int m);
		return 16'((`GEAR_BASE + 3) * n / m);
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		// Ready is judged at the rising edge itself; the request stands until then
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(n < 20, 1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_state(input logic [2:0] exp);
		int n;
		n = 0;
		while (pstate !== exp && n < 400) begin
			@(negedge i_clk);
			n++;
		end
		chk(pstate, exp);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_refuse;
		apb(1'b0, `A_STATUS, 32'h0000_0000);
		chk(rdata & 32'h0000_0700, 32'h0000_0000);
		apb(1'b1, `A_CMD, 32'h0004_0001);
		chk(rerr, 1);
		apb(1'b1, `A_CMD, 32'h0004_0002);
		chk(rerr, 1);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({rerr, rdata[30:0]}, 32'h8000_0000);
	endtask
	task t_wake;
		apb(1'b1, `A_PINS, 32'h0000_0037);
		wait_state(3'h2);
		apb(1'b0, `A_FREQ, 32'h0000_0000);
		chk(rdata[15:0], f(`STD_N, `STD_M));
	endtask
	task t_prog;
		apb(1'b1, `A_CMD, 32'h0001_092C);
		apb(1'b1, `A_CMD, 32'h0004_000D);
		repeat (4) @(posedge i_clk);
		apb(1'b0, `A_FREQ, 32'h0000_0000);
		chk(rdata[15:0], f(300, 4));
		chk(owner, 1);
		apb(1'b1, `A_CMD, 32'h0002_00C8);
		repeat (4) @(posedge i_clk);
		apb(1'b0, `A_FREQ, 32'h0000_0000);
		chk(rdata[15:0], f(200, 4));
	endtask
	task t_ramp;
		int n;
		n = 0;
		apb(1'b1, `A_CMD, 32'h0004_0005);
		apb(1'b1, `A_CMD, 32'h0002_00CC);
		while (link.cpu_freq !== f(204, 4) && n < 4000) begin
			@(negedge i_clk);
			n++;
		end
		chk(link.cpu_freq, f(204, 4));
		chk(n >= 18 * `SLEW_CYC, 1);
	endtask
	task t_stops;
		apb(1'b1, `A_PINS, 32'h0000_0035);
		repeat (40) @(posedge i_clk);
		apb(1'b0, `A_STATUS, 32'h0000_0000);
		chk(rdata & 32'h0000_0003, 32'h0000_0001);
		apb(1'b1, `A_PINS, 32'h0000_0033);
		repeat (40) @(posedge i_clk);
		apb(1'b0, `A_STATUS, 32'h0000_0000);
		chk(rdata & 32'h0000_0034, 32'h0000_0010);
		apb(1'b1, `A_PINS, 32'h0000_0037);
		repeat (20) @(posedge i_clk);
	endtask
	task t_pd(input logic [15:0] b0, input logic [2:0] st, input logic [15:0] fx);
		apb(1'b1, `A_CMD, {16'h0000, b0});
		apb(1'b1, `A_PINS, 32'h0000_0036);
		wait_state(st);
		apb(1'b1, `A_PINS, 32'h0000_0037);
		wait_state(3'h2);
		apb(1'b0, `A_FREQ, 32'h0000_0000);
		chk(rdata[15:0], fx);
	endtask
	task give_verdict;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_refuse;
		t_wake;
		t_prog;
		t_ramp;
		t_stops;
		t_pd(16'h0001, 3'h4, f(204, 4));
		t_pd(16'h0008, 3'h4, f(204, 4));
		t_pd(16'h0000, 3'h0, f(`STD_N, `STD_M));
		give_verdict;
	end
	// Watchdog: the ramp dominates, about 3200 cycles; 100k cycles is ample
	initial begin
		#400000;
		n_errors++;
		give_verdict;
	end
endmodule
